//--- tlvic_pkg.sv
// How it works
// R1 - sample and arbitrate pending requests every clock
// R2 - detect plus five call cycles: six best
// R3 - one instruction after return before next call
// R4 - worst case twenty clocks with return and divide
// R5 - equal or lower level waits for return
// R6 - core stall defers servicing, adds to latency
// R7 - reset vector zero; others 0x0003 plus 8*index
// R8 - same level: lowest fixed index wins
// R9 - vectoring clears flags of sources 0 to 3
// R10 - global gate bit 7 blocks every source
// R11 - primary enable bits 6..0 fixed source order
// R12 - multi-flag source requests when any flag set
// R13 - indices 7..14 and 15..16 in extended enables
// R14 - level bit sits at its enable bit position
// R15 - primary enable resets to zero
// R16 - high preempts low; high never preempted
// R17 - flag still set after return requests again
// R18 - flags set regardless of enable, software too
// R19 - core acknowledges request; level pushed on stack
package tlvic_pkg;
    localparam int         NSRC          = 17;
    localparam int         NHWCLR        = 4;
    localparam logic [7:0] OFS_ENABLE    = 8'ha8;
    localparam logic [7:0] OFS_LEVEL     = 8'hb8;
    localparam logic [7:0] OFS_EXT_EN_A  = 8'hc0;
    localparam logic [7:0] OFS_EXT_EN_B  = 8'hc4;
    localparam logic [7:0] OFS_EXT_LV_A  = 8'hc8;
    localparam logic [7:0] OFS_EXT_LV_B  = 8'hcc;
    localparam logic [7:0] OFS_PEND      = 8'hd0;
    localparam logic [7:0] OFS_PEND_SET  = 8'hd4;
    localparam logic [7:0] OFS_PEND_CLR  = 8'hd8;
    localparam logic [7:0] OFS_STATUS    = 8'hdc;
    localparam logic [7:0] OFS_MASK      = 8'he0;
    localparam logic [7:0] OFS_ACTIVE    = 8'he4;
    localparam logic [7:0] RST_ENABLE    = 8'h00;
    localparam logic [7:0] RST_LEVEL     = 8'h80;
    localparam int         GATE_BIT      = 7;
    localparam int         EXT_B_BITS    = 2;
    localparam logic [15:0] RESET_VEC    = 16'h0000;
    localparam logic [15:0] VEC_BASE     = 16'h0003;
    localparam int         VEC_STEP_SH   = 3;
    localparam int         DETECT_CYC    = 1;
    localparam int         CALL_CYC      = 5;
    localparam logic [2:0] CALL_CNT_INIT = 3'(CALL_CYC - DETECT_CYC - 1);
    localparam int         ST_ENTRY      = 0;
    localparam int         ST_RETURN     = 1;

    typedef enum logic [0:0] {
        TLVIC_IDLE = 1'b0,
        TLVIC_CALL = 1'b1
    } tlvic_state_t;

    typedef struct packed {
        logic        req;
        logic        level;
        logic [15:0] vector;
    } tlvic_grant_t;
endpackage

//--- tlvic_unit.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module tlvic_unit
    import tlvic_pkg::*;
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // peripheral flags
    input  wire logic [NHWCLR-1:0]   src_event,
    input  wire logic                uart_a_rx_flag,
    input  wire logic                uart_a_tx_flag,
    input  wire logic                timer2_low_overflow_flag,
    input  wire logic                timer2_high_overflow_flag,
    input  wire logic [15:6]         src_level,
    input  wire logic                uart_b_rx_flag,
    input  wire logic                uart_b_tx_flag,
    // core sequencer
    input  wire logic                core_stall,
    input  wire logic                core_ack,
    input  wire logic                core_return_irq_instr,
    input  wire logic                core_instr_done,
    output tlvic_grant_t             grant,
    output logic                     entry_q,
    output logic [15:0]              entry_vector_q,
    // interrupt to system
    output logic                     irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0]      irq_source_enable_q;
    logic [7:0]      irq_level_select_q;
    logic [7:0]      ext_enable_reg_a_q;
    logic [EXT_B_BITS-1:0] ext_enable_reg_b_q;
    logic [7:0]      ext_level_reg_a_q;
    logic [EXT_B_BITS-1:0] ext_level_reg_b_q;
    logic [NSRC-1:0] lat_q;
    logic [NSRC-1:0] lat_d;
    logic [NSRC-1:0] pend_q;
    logic [1:0]      stat_q;
    logic [1:0]      mask_q;
    logic [1:0]      act_q;
    logic            hold_q;
    logic [2:0]      cnt_q;
    logic [4:0]      idx_q;
    tlvic_state_t    state_q;

    logic            wr_en;
    logic            setup;
    logic [NSRC-1:0] raw;
    logic [NSRC-1:0] en;
    logic [NSRC-1:0] lv;
    logic [NSRC-1:0] cand;
    logic [NSRC-1:0] sw_set;
    logic [NSRC-1:0] sw_clr;
    logic [NSRC-1:0] hw_clr;
    logic [4:0]      hi_idx;
    logic [4:0]      lo_idx;
    logic            hi_any;
    logic            lo_any;
    logic [4:0]      sel_idx;
    logic            sel_lvl;
    logic            sel_ok;
    logic            take;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // lowest index wins inside one level
    function automatic logic [5:0] first_set(input logic [NSRC-1:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, read data captured in setup

    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pwrite;
    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_source_enable_q <= RST_ENABLE; // R15
            irq_level_select_q  <= RST_LEVEL;
            ext_enable_reg_a_q  <= 8'h00;
            ext_enable_reg_b_q  <= 2'h0;
            ext_level_reg_a_q   <= 8'h00;
            ext_level_reg_b_q   <= 2'h0;
            mask_q              <= 2'h0;
        end else if (wr_en) begin
            if (hit(paddr, OFS_ENABLE)) begin
                irq_source_enable_q <= pwdata[7:0];
            end
            if (hit(paddr, OFS_LEVEL)) begin
                irq_level_select_q <= {1'b1, pwdata[6:0]};
            end
            if (hit(paddr, OFS_EXT_EN_A)) begin
                ext_enable_reg_a_q <= pwdata[7:0];
            end
            if (hit(paddr, OFS_EXT_EN_B)) begin
                ext_enable_reg_b_q <= pwdata[EXT_B_BITS-1:0];
            end
            if (hit(paddr, OFS_EXT_LV_A)) begin
                ext_level_reg_a_q <= pwdata[7:0];
            end
            if (hit(paddr, OFS_EXT_LV_B)) begin
                ext_level_reg_b_q <= pwdata[EXT_B_BITS-1:0];
            end
            if (hit(paddr, OFS_MASK)) begin
                mask_q <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= 1'b0;
            unique case (paddr)
                OFS_ENABLE:   prdata <= {24'h0, irq_source_enable_q};
                OFS_LEVEL:    prdata <= {24'h0, irq_level_select_q};
                OFS_EXT_EN_A: prdata <= {24'h0, ext_enable_reg_a_q};
                OFS_EXT_EN_B: prdata <= {30'h0, ext_enable_reg_b_q};
                OFS_EXT_LV_A: prdata <= {24'h0, ext_level_reg_a_q};
                OFS_EXT_LV_B: prdata <= {30'h0, ext_level_reg_b_q};
                OFS_PEND:     prdata <= {15'h0, raw};
                OFS_STATUS:   prdata <= {30'h0, stat_q};
                OFS_MASK:     prdata <= {30'h0, mask_q};
                OFS_ACTIVE:   prdata <= {30'h0, act_q};
                OFS_PEND_SET,
                OFS_PEND_CLR: prdata <= 32'h0000_0000;
                default: begin
                    prdata  <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pending flags

    assign sw_set = (wr_en && hit(paddr, OFS_PEND_SET)) ? pwdata[NSRC-1:0]
                                                        : '0; // R18
    assign sw_clr = (wr_en && hit(paddr, OFS_PEND_CLR)) ? pwdata[NSRC-1:0]
                                                        : '0;
    // only the first four sources lose their flag on vectoring
    assign hw_clr = (take && sel_idx < 5'(NHWCLR))
                  ? (NSRC'(1) << sel_idx) : '0; // R9

    // a set in the same cycle as a clear wins
    assign lat_d = (lat_q & ~(sw_clr | hw_clr))
                 | sw_set | {13'h0, src_event}; // R18

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_q <= '0;
        end else begin
            lat_q <= lat_d;
        end
    end

    // several flags of one source fold into one request
    assign raw = lat_q | {uart_b_rx_flag | uart_b_tx_flag, src_level,
                 timer2_low_overflow_flag | timer2_high_overflow_flag,
                 uart_a_rx_flag | uart_a_tx_flag, 4'h0}; // R12

    // one detect cycle; sampled every clock whatever the enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= raw; // R1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable, level, arbitration

    assign en = {ext_enable_reg_b_q, ext_enable_reg_a_q,
                 irq_source_enable_q[6:0]}
              & {NSRC{irq_source_enable_q[GATE_BIT]}}; // R10 R11 R13
    assign lv = {ext_level_reg_b_q, ext_level_reg_a_q,
                 irq_level_select_q[6:0]}; // R14
    assign cand = pend_q & en;

    assign {hi_any, hi_idx} = first_set(cand & lv);
    assign {lo_any, lo_idx} = first_set(cand & ~lv);

    // high level first, then fixed order
    assign sel_lvl = hi_any;
    assign sel_idx = hi_any ? hi_idx : lo_idx; // R8

    // nothing preempts high; only high preempts low
    assign sel_ok = sel_lvl ? !act_q[1]
                            : (lo_any && act_q == 2'b00); // R5 R16

    assign grant.req = sel_ok && state_q == TLVIC_IDLE && !core_stall
                     && !hold_q; // R3 R6 R17
    assign grant.level  = sel_lvl;
    assign grant.vector = VEC_BASE
                        + 16'({sel_idx, 3'b000}); // R7
    assign take = grant.req && core_ack; // R19

    ////////////////////////////////////////////////////////////////////////
    // long call sequencing

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q        <= TLVIC_IDLE;
            cnt_q          <= 3'h0;
            idx_q          <= 5'h00;
            entry_q        <= 1'b0;
            entry_vector_q <= RESET_VEC; // R7
        end else begin
            entry_q <= 1'b0;
            unique case (state_q)
                TLVIC_IDLE: begin
                    if (take) begin
                        state_q <= TLVIC_CALL;
                        cnt_q   <= CALL_CNT_INIT; // R2 R4
                        idx_q   <= sel_idx;
                    end
                end
                TLVIC_CALL: begin
                    if (cnt_q == 3'h0) begin
                        state_q        <= TLVIC_IDLE;
                        entry_q        <= 1'b1; // R2
                        entry_vector_q <= VEC_BASE
                                        + 16'({idx_q, 3'b000}); // R7
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
            endcase
        end
    end

    // two-entry level stack; pop clears the highest level first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= 2'b00;
        end else if (take) begin
            act_q[sel_lvl] <= 1'b1; // R19
        end else if (core_return_irq_instr) begin
            if (act_q[1]) begin
                act_q[1] <= 1'b0;
            end else begin
                act_q[0] <= 1'b0;
            end
        end
    end

    // after a return, one instruction must complete first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 1'b0;
        end else if (core_return_irq_instr) begin
            hold_q <= 1'b1; // R3 R17
        end else if (core_instr_done) begin
            hold_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status, write one to clear; set beats clear

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 2'b00;
        end else begin
            stat_q[ST_ENTRY] <= entry_q || (stat_q[ST_ENTRY]
                && !(wr_en && hit(paddr, OFS_STATUS)
                     && pwdata[ST_ENTRY]));
            stat_q[ST_RETURN] <= core_return_irq_instr || (stat_q[ST_RETURN]
                && !(wr_en && hit(paddr, OFS_STATUS)
                     && pwdata[ST_RETURN]));
        end
    end

    assign irq_out = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_call_length: assert property (@(posedge pclk) disable iff (!presetn)
        take |=> !entry_q [*4] ##1 entry_q) // R2
        else $error("entry not five cycles after acknowledge");

    a_global_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !irq_source_enable_q[GATE_BIT] |-> !grant.req) // R10
        else $error("request raised with global gate off");

    a_return_irq_instr_hold: assert property (@(posedge pclk) disable iff (!presetn)
        core_return_irq_instr |=> !grant.req) // R3
        else $error("request right after return");

    a_stall_defer: assert property (@(posedge pclk) disable iff (!presetn)
        core_stall |-> !grant.req) // R6
        else $error("request during core stall");

    a_high_nopreempt: assert property (@(posedge pclk)
        disable iff (!presetn)
        act_q[1] |-> !grant.req) // R16
        else $error("high level routine preempted");

    a_low_preempt: assert property (@(posedge pclk) disable iff (!presetn)
        (act_q[0] && grant.req) |-> grant.level) // R5
        else $error("equal level preempted low routine");

    a_vector_map: assert property (@(posedge pclk) disable iff (!presetn)
        take |-> ##5 (entry_vector_q
            == VEC_BASE + 16'({$past(sel_idx, 5), 3'b000}))) // R7
        else $error("entry vector does not match granted source");

    a_hw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (take && sel_idx == 5'h00 && !src_event[0] && !sw_set[0])
        |=> !lat_q[0]) // R9
        else $error("external input 0 flag not cleared on vectoring");

endmodule // tlvic_unit

//--- tlvic_core_model.sv
`timescale 1ns/1ps
module tlvic_core_model
    import tlvic_pkg::*;
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // unit side
    input  wire tlvic_grant_t grant,
    input  wire logic         entry_q,
    output logic              core_ack,
    output logic              core_stall,
    output logic              core_return_irq_instr,
    output logic              core_instr_done,
    // bench control
    input  wire logic         stall_in,
    input  wire logic         hold_in,
    input  wire logic         return_irq_instr_go
);
    logic       busy_q;
    logic [1:0] cnt_q;
    ////////////////////////////////////////////////////////////////////////
    // ack only while a request stands; hold_in models a slow boundary
    assign core_ack = grant.req & ~busy_q & ~core_stall & ~hold_in;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else if (core_ack) begin
            busy_q <= 1'b1;
        end else if (entry_q) begin
            busy_q <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_stall <= 1'b0;
        end else begin
            core_stall <= stall_in;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // one short instruction always follows a return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_return_irq_instr       <= 1'b0;
            core_instr_done <= 1'b0;
            cnt_q           <= 2'h0;
        end else begin
            core_return_irq_instr       <= return_irq_instr_go;
            core_instr_done <= (cnt_q == 2'h1);
            cnt_q           <= return_irq_instr_go ? 2'h3 : cnt_q - 2'(cnt_q != 2'h0);
        end
    end
endmodule // tlvic_core_model

//--- two_level_vectored_irq_unit_tb.sv
`timescale 1ns/1ps
module two_level_vectored_irq_unit_tb import tlvic_pkg::*;;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [3:0]   src_ev;
    logic         ua_rx, ua_tx, t2l, t2h, ub_rx, ub_tx, err;
    logic [15:6]  src_lv;
    logic         stall_in, hold_in, return_irq_instr_go, irq_out, entry_q;
    logic         core_ack, core_stall, core_return_irq_instr, core_instr_done;
    logic [15:0]  entry_vector_q;
    logic [16:0]  msk, en;
    tlvic_grant_t grant;
    int           mismatches, tests_run, n, k;
    int           tbl [7] = '{4, 4, 5, 5, 16, 16, 9};
    tlvic_unit tlvic_unit_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .src_event(src_ev), .uart_a_rx_flag(ua_rx),
        .uart_a_tx_flag(ua_tx), .timer2_low_overflow_flag(t2l),
        .timer2_high_overflow_flag(t2h), .src_level(src_lv),
        .uart_b_rx_flag(ub_rx), .uart_b_tx_flag(ub_tx),
        .core_stall(core_stall), .core_ack(core_ack),
        .core_return_irq_instr(core_return_irq_instr), .core_instr_done(core_instr_done),
        .grant(grant), .entry_q(entry_q),
        .entry_vector_q(entry_vector_q), .irq_out(irq_out));
    tlvic_core_model tlvic_core_model_inst (.pclk(pclk),
        .presetn(presetn), .grant(grant), .entry_q(entry_q),
        .core_ack(core_ack), .core_stall(core_stall),
        .core_return_irq_instr(core_return_irq_instr), .core_instr_done(core_instr_done),
        .stall_in(stall_in), .hold_in(hold_in), .return_irq_instr_go(return_irq_instr_go));
    ////////////////////////////////////////////////////////////////////////
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;
    function automatic logic [15:0] vec(input int i);
        return 16'h0003 + 16'(i * 8);
    endfunction
    function automatic int low_idx(input logic [16:0] m);
        for (int i = 0; i < 17; i++) begin
            if (m[i]) return i;
        end
        return -1;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    // event inputs are one-cycle pulses, so drop them on the first cycle
    task wait_entry;
        n = 0;
        do begin
            @(posedge pclk);
            src_ev <= 4'h0;
            n++;
            @(negedge pclk);
        end while (entry_q !== 1'b1 && n < 100);
        if (entry_q !== 1'b1) mismatches++;
    endtask
    task isr_end;
        @(posedge pclk);
        return_irq_instr_go <= 1'b1;
        @(posedge pclk);
        return_irq_instr_go <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    task all_en;
        apb(1'b1, OFS_ENABLE, 32'hff);
        apb(1'b1, OFS_EXT_EN_A, 32'hff);
        apb(1'b1, OFS_EXT_EN_B, 32'h3);
    endtask
    // long hangs end here and still give a verdict
    initial begin
        #400000;
        mismatches++;
        final_report;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {src_ev, ua_rx, ua_tx, t2l, t2h, ub_rx, ub_tx, src_lv} = '0;
        {stall_in, hold_in, return_irq_instr_go, presetn} = '0;
        {mismatches, tests_run} = '0;
        k = $urandom(11);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_ENABLE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFS_LEVEL, 32'h0);
        chk(rd, 32'h80);
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        chk(entry_vector_q, 16'h0000);
        @(posedge pclk);
        src_ev <= 4'h2;
        @(posedge pclk);
        src_ev <= 4'h0;
        apb(1'b0, OFS_PEND, 32'h0);
        chk(rd[1], 1'b1);
        apb(1'b1, OFS_ENABLE, 32'h7f);
        chk(grant.req, 1'b0);
        apb(1'b1, OFS_PEND_CLR, 32'h1ffff);
        all_en;
        apb(1'b1, OFS_MASK, 32'h1);
        @(posedge pclk);
        src_ev <= 4'h8;
        wait_entry;
        // the pulse needs one edge to become the flag, then six
        chk(n, 7);
        chk(entry_vector_q, 16'h001b);
        @(negedge pclk);
        chk(irq_out, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h1);
        chk(irq_out, 1'b0);
        apb(1'b0, OFS_PEND, 32'h0);
        chk(rd[3], 1'b0);
        isr_end;
        @(posedge pclk);
        stall_in <= 1'b1;
        src_ev <= 4'h1;
        repeat (4) begin
            @(posedge pclk);
            #1 chk(grant.req, 1'b0);
        end
        @(posedge pclk);
        src_ev <= 4'h0;
        stall_in <= 1'b0;
        wait_entry;
        chk(entry_vector_q, 16'h0003);
        isr_end;
        // slow core: the request must stand until taken
        hold_in <= 1'b1;
        apb(1'b1, OFS_PEND_SET, 32'h10);
        repeat (3) @(posedge pclk);
        chk({grant.req, grant.level, grant.vector}, {2'b10, 16'h0023});
        hold_in <= 1'b0;
        wait_entry;
        chk(entry_vector_q, 16'h0023);
        apb(1'b1, OFS_PEND_CLR, 32'h10);
        isr_end;
        for (k = 0; k < 7; k++) begin
            @(posedge pclk);
            {ub_tx, ub_rx, t2h, t2l, ua_tx, ua_rx} <= 6'(1 << k);
            src_lv[9] <= (k == 6);
            wait_entry;
            chk(entry_vector_q, vec(tbl[k]));
            @(posedge pclk);
            {ub_tx, ub_rx, t2h, t2l, ua_tx, ua_rx, src_lv[9]} <= '0;
            isr_end;
        end
        for (k = 0; k < 8; k++) begin
            msk = 17'($urandom);
            en = 17'($urandom);
            apb(1'b1, OFS_ENABLE, {24'h0, 1'b1, en[6:0]});
            apb(1'b1, OFS_EXT_EN_A, {24'h0, en[14:7]});
            apb(1'b1, OFS_EXT_EN_B, {30'h0, en[16:15]});
            apb(1'b1, OFS_PEND_SET, {15'h0, msk});
            if ((msk & en) == 17'h0) begin
                repeat (3) @(posedge pclk);
                chk(grant.req, 1'b0);
            end else begin
                wait_entry;
                chk(entry_vector_q, vec(low_idx(msk & en)));
            end
            apb(1'b1, OFS_PEND_CLR, 32'h1ffff);
            if ((msk & en) != 17'h0) isr_end;
        end
        all_en;
        apb(1'b1, OFS_LEVEL, 32'h05);
        apb(1'b1, OFS_PEND_SET, 32'h10);
        wait_entry;
        @(posedge pclk);
        src_ev <= 4'h4;
        wait_entry;
        chk(entry_vector_q, 16'h0013);
        apb(1'b0, OFS_ACTIVE, 32'h0);
        chk(rd, 32'h3);
        @(posedge pclk);
        src_ev <= 4'h1;
        repeat (4) begin
            @(posedge pclk);
            src_ev <= 4'h0;
            #1 chk(grant.req, 1'b0);
        end
        isr_end;
        wait_entry;
        chk(entry_vector_q, 16'h0003);
        isr_end;
        chk(grant.req, 1'b0);
        apb(1'b1, OFS_PEND_CLR, 32'h10);
        isr_end;
        apb(1'b1, OFS_PEND_SET, 32'h20);
        wait_entry;
        @(posedge pclk);
        return_irq_instr_go <= 1'b1;
        @(posedge pclk);
        return_irq_instr_go <= 1'b0;
        @(posedge pclk);
        #1 chk(grant.req, 1'b0);
        wait_entry;
        chk({n < 20, entry_vector_q}, {1'b1, 16'h002b});
        apb(1'b1, OFS_PEND_CLR, 32'h20);
        isr_end;
        final_report;
    end
endmodule // two_level_vectored_irq_unit_tb
